/* File: tfc_consts.vh */
// Purpose: Constants shared by the transfer controller design files
// Assumes: Included by bare name from each design file
// Notes:   Definitions only
`ifndef TFC_CONSTS_VH
`define TFC_CONSTS_VH

// ----------------------------------------------------------------
// Register offsets (byte addresses on the register port)
// ----------------------------------------------------------------
`define TFC_OFF_CTRL     8'h00
`define TFC_OFF_DESC     8'h04
`define TFC_OFF_SWACT    8'h08
`define TFC_OFF_STAT     8'h0c

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TFC_CTRL_RST     1'h0
`define TFC_DESC_RST     24'h000000

// ----------------------------------------------------------------
// Mode word A fields
// ----------------------------------------------------------------
`define TFC_MRA_SM_HI    7
`define TFC_MRA_SM_LO    6
`define TFC_MRA_DM_HI    5
`define TFC_MRA_DM_LO    4
`define TFC_MRA_MD_HI    3
`define TFC_MRA_MD_LO    2
`define TFC_MRA_DTS      1
`define TFC_MRA_SZ       0

// ----------------------------------------------------------------
// Mode word B fields
// ----------------------------------------------------------------
`define TFC_MRB_CHAIN    7
`define TFC_MRB_IRQSEL   6

// ----------------------------------------------------------------
// Transfer modes
// ----------------------------------------------------------------
`define TFC_MD_NORMAL    2'h0
`define TFC_MD_REPEAT    2'h1
`define TFC_MD_BLOCK     2'h2

// ----------------------------------------------------------------
// Descriptor layout in memory
// ----------------------------------------------------------------
`define TFC_DESC_LAST    3'h5
`define TFC_DESC_BYTES   24'h00000c

`endif

/* File: tfc_step.v */
// Purpose: Computes descriptor state after one data unit has moved
// Assumes: Pure combinational; caller latches the results
// Notes:   Zero counts wrap, so they act as the largest count
`default_nettype none
`include "tfc_consts.vh"

module tfc_step (
    input  wire [7:0]  mode_a_in,
    input  wire [23:0] sar_in,
    input  wire [23:0] dar_in,
    input  wire [15:0] cra_in,
    input  wire [15:0] crb_in,
    output reg  [23:0] sar_out,
    output reg  [23:0] dar_out,
    output reg  [15:0] cra_out,
    output reg  [15:0] crb_out,
    output reg         last_out,
    output reg         end_out
);

    // ----------------------------------------------------------------
    // Address helpers
    // ----------------------------------------------------------------
    function [23:0] adv;
        input [23:0] a;
        input [1:0]  m;
        input        w;
        begin
            if (m[1])
                adv = m[0] ? a - {22'h000000, w, ~w} : a + {22'h000000, w, ~w};
            else
                adv = a;
        end
    endfunction

    // Undo a whole area's worth of steps; n of zero stands for 256 units
    function [23:0] rewind;
        input [23:0] a;
        input [1:0]  m;
        input        w;
        input [7:0]  n;
        reg   [9:0]  span;
        begin
            span = (n == 8'h00) ? (10'h100 << w) : ({2'h0, n} << w);
            if (m[1])
                rewind = m[0] ? a + {14'h0000, span} : a - {14'h0000, span};
            else
                rewind = a;
        end
    endfunction

    reg [23:0] sar_mv;
    reg [23:0] dar_mv;
    reg [7:0]  low_n;
    reg [15:0] blk_n;
    reg [1:0]  md;
    reg        w;

    always @*
    begin
        md      = mode_a_in[`TFC_MRA_MD_HI:`TFC_MRA_MD_LO];
        w       = mode_a_in[`TFC_MRA_SZ];
        sar_mv  = adv(sar_in, mode_a_in[`TFC_MRA_SM_HI:`TFC_MRA_SM_LO], w);
        dar_mv  = adv(dar_in, mode_a_in[`TFC_MRA_DM_HI:`TFC_MRA_DM_LO], w);
        low_n   = cra_in[7:0] - 8'h01;
        blk_n   = crb_in - 16'h0001;
        sar_out = sar_mv;
        dar_out = dar_mv;
        cra_out = cra_in - 16'h0001;
        crb_out = crb_in;
        last_out = 1'b1;
        end_out = (cra_in == 16'h0001);
        case (md)
            `TFC_MD_REPEAT, `TFC_MD_BLOCK:
            begin
                cra_out = {cra_in[15:8], low_n};
                end_out = 1'b0;
                if (md == `TFC_MD_BLOCK && low_n != 8'h00)
                    last_out = 1'b0;
                if (low_n == 8'h00)
                begin
                    cra_out = {cra_in[15:8], cra_in[15:8]};
                    if (mode_a_in[`TFC_MRA_DTS])
                        sar_out = rewind(sar_mv, mode_a_in[`TFC_MRA_SM_HI:`TFC_MRA_SM_LO], w, cra_in[15:8]);
                    else
                        dar_out = rewind(dar_mv, mode_a_in[`TFC_MRA_DM_HI:`TFC_MRA_DM_LO], w, cra_in[15:8]);
                    if (md == `TFC_MD_BLOCK)
                    begin
                        crb_out = blk_n;
                        end_out = (blk_n == 16'h0000);
                    end
                end
            end
            default:
            begin
                last_out = 1'b1;
            end
        endcase
    end

endmodule
`default_nettype wire

/* File: tfc_core.v */
// Purpose: Descriptor-driven transfer controller: normal, repeat, block, chain
// Assumes: Memory answers a read in the cycle after its strobe, never waits
// Notes:   Activation source must drop its request after act_ack_out
//
// The implementer's own choices: the register addresses and strobed register access.
`default_nettype none
`include "tfc_consts.vh"

module tfc_core (
    input  wire        mclk_in,
    input  wire        nrst_in,
    input  wire [7:0]  reg_addr_in,
    input  wire [31:0] reg_wdata_in,
    input  wire        reg_wr_in,
    input  wire        reg_rd_in,
    output reg  [31:0] reg_rdata_out,
    input  wire        act_req_in,
    input  wire [23:0] act_addr_in,
    output reg         act_ack_out,
    output reg  [23:0] mem_addr_out,
    output reg  [15:0] mem_wdata_out,
    output reg         mem_wr_out,
    output reg         mem_rd_out,
    output reg         mem_word_out,
    input  wire [15:0] mem_rdata_in,
    output reg         cpu_irq_out,
    output reg         src_flag_clr_out,
    output reg         busy_out
);

    // ----------------------------------------------------------------
    // States
    // ----------------------------------------------------------------
    localparam [3:0] S_IDLE  = 4'h0;
    localparam [3:0] S_FREQ  = 4'h1;
    localparam [3:0] S_FHOLD = 4'h2;
    localparam [3:0] S_FCAP  = 4'h3;
    localparam [3:0] S_XREQ  = 4'h4;
    localparam [3:0] S_XHOLD = 4'h5;
    localparam [3:0] S_XCAP  = 4'h6;
    localparam [3:0] S_XWR   = 4'h7;
    localparam [3:0] S_UPD   = 4'h8;
    localparam [3:0] S_WB    = 4'h9;
    localparam [3:0] S_FIN   = 4'ha;

    reg [3:0]  state_q;
    reg [2:0]  idx_q;
    reg [23:0] base_q;
    reg [7:0]  mra_q;
    reg [7:0]  mrb_q;
    reg [23:0] sar_q;
    reg [23:0] dar_q;
    reg [15:0] cra_q;
    reg [15:0] crb_q;
    reg        end_q;
    reg        from_sw_q;
    reg        ctrl_en_q;
    reg [23:0] desc_q;
    reg        sw_pend_q;
    reg        sw_flag_q;
    reg        last_irq_q;

    wire [23:0] st_sar;
    wire [23:0] st_dar;
    wire [15:0] st_cra;
    wire [15:0] st_crb;
    wire        st_last;
    wire        st_end;

    // ----------------------------------------------------------------
    // Descriptor helpers
    // ----------------------------------------------------------------
    // Word n sits at base plus 2n
    function [23:0] desc_addr;
        input [23:0] b;
        input [2:0]  n;
        begin
            desc_addr = b + {20'h00000, n, 1'b0};
        end
    endfunction

    function [15:0] desc_word;
        input [2:0] n;
        begin
            case (n)
                3'h0:    desc_word = {mra_q, sar_q[23:16]};
                3'h1:    desc_word = sar_q[15:0];
                3'h2:    desc_word = {mrb_q, dar_q[23:16]};
                3'h3:    desc_word = dar_q[15:0];
                3'h4:    desc_word = cra_q;
                default: desc_word = crb_q;
            endcase
        end
    endfunction

    // ----------------------------------------------------------------
    // Per-unit update
    // ----------------------------------------------------------------
    // Only the loaded descriptor feeds the update
    tfc_step u_step (
        .mode_a_in (mra_q),
        .sar_in    (sar_q),
        .dar_in    (dar_q),
        .cra_in    (cra_q),
        .crb_in    (crb_q),
        .sar_out   (st_sar),
        .dar_out   (st_dar),
        .cra_out   (st_cra),
        .crb_out   (st_crb),
        .last_out  (st_last),
        .end_out   (st_end)
    );

    // ----------------------------------------------------------------
    // Sequencer and register port
    // ----------------------------------------------------------------
    always @(posedge mclk_in or negedge nrst_in)
    begin
        if (!nrst_in)
        begin
            state_q          <= S_IDLE;
            idx_q            <= 3'h0;
            base_q           <= 24'h000000;
            mra_q            <= 8'h00;
            mrb_q            <= 8'h00;
            sar_q            <= 24'h000000;
            dar_q            <= 24'h000000;
            cra_q            <= 16'h0000;
            crb_q            <= 16'h0000;
            end_q            <= 1'b0;
            from_sw_q        <= 1'b0;
            ctrl_en_q        <= `TFC_CTRL_RST;
            desc_q           <= `TFC_DESC_RST;
            sw_pend_q        <= 1'b0;
            sw_flag_q        <= 1'b0;
            last_irq_q       <= 1'b0;
            reg_rdata_out    <= 32'h00000000;
            act_ack_out      <= 1'b0;
            mem_addr_out     <= 24'h000000;
            mem_wdata_out    <= 16'h0000;
            mem_wr_out       <= 1'b0;
            mem_rd_out       <= 1'b0;
            mem_word_out     <= 1'b0;
            cpu_irq_out      <= 1'b0;
            src_flag_clr_out <= 1'b0;
            busy_out         <= 1'b0;
        end
        else
        begin
            act_ack_out      <= 1'b0;
            cpu_irq_out      <= 1'b0;
            src_flag_clr_out <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    idx_q <= 3'h0;
                    // Software start outranks a peripheral request
                    if (ctrl_en_q && sw_pend_q)
                    begin
                        base_q    <= {desc_q[23:2], 2'h0};
                        from_sw_q <= 1'b1;
                        sw_pend_q <= 1'b0;
                        busy_out  <= 1'b1;
                        state_q   <= S_FREQ;
                    end
                    else if (ctrl_en_q && act_req_in)
                    begin
                        base_q      <= {act_addr_in[23:2], 2'h0};
                        from_sw_q   <= 1'b0;
                        act_ack_out <= 1'b1;
                        busy_out    <= 1'b1;
                        state_q     <= S_FREQ;
                    end
                end
                S_FREQ:
                begin
                    mem_rd_out   <= 1'b1;
                    mem_word_out <= 1'b1;
                    mem_addr_out <= desc_addr(base_q, idx_q);
                    state_q      <= S_FHOLD;
                end
                S_FHOLD:
                begin
                    mem_rd_out <= 1'b0;
                    state_q    <= S_FCAP;
                end
                S_FCAP:
                begin
                    case (idx_q)
                        3'h0:
                        begin
                            mra_q         <= mem_rdata_in[15:8];
                            sar_q[23:16]  <= mem_rdata_in[7:0];
                        end
                        3'h1:    sar_q[15:0] <= mem_rdata_in;
                        3'h2:
                        begin
                            mrb_q         <= mem_rdata_in[15:8];
                            dar_q[23:16]  <= mem_rdata_in[7:0];
                        end
                        3'h3:    dar_q[15:0] <= mem_rdata_in;
                        3'h4:    cra_q <= mem_rdata_in;
                        default: crb_q <= mem_rdata_in;
                    endcase
                    if (idx_q == `TFC_DESC_LAST)
                    begin
                        idx_q   <= 3'h0;
                        state_q <= S_XREQ;
                    end
                    else
                    begin
                        idx_q   <= idx_q + 3'h1;
                        state_q <= S_FREQ;
                    end
                end
                S_XREQ:
                begin
                    mem_rd_out   <= 1'b1;
                    mem_word_out <= mra_q[`TFC_MRA_SZ];
                    mem_addr_out <= sar_q;
                    state_q      <= S_XHOLD;
                end
                S_XHOLD:
                begin
                    mem_rd_out <= 1'b0;
                    state_q    <= S_XCAP;
                end
                S_XCAP:
                begin
                    mem_wr_out    <= 1'b1;
                    mem_addr_out  <= dar_q;
                    mem_wdata_out <= mra_q[`TFC_MRA_SZ] ? mem_rdata_in : {8'h00, mem_rdata_in[7:0]};
                    state_q       <= S_XWR;
                end
                S_XWR:
                begin
                    mem_wr_out <= 1'b0;
                    state_q    <= S_UPD;
                end
                S_UPD:
                begin
                    sar_q <= st_sar;
                    dar_q <= st_dar;
                    cra_q <= st_cra;
                    crb_q <= st_crb;
                    end_q <= st_end;
                    state_q <= st_last ? S_WB : S_XREQ;
                end
                S_WB:
                begin
                    mem_wr_out    <= 1'b1;
                    mem_word_out  <= 1'b1;
                    mem_addr_out  <= desc_addr(base_q, idx_q);
                    mem_wdata_out <= desc_word(idx_q);
                    if (idx_q == `TFC_DESC_LAST)
                        state_q <= S_FIN;
                    else
                        idx_q <= idx_q + 3'h1;
                end
                S_FIN:
                begin
                    mem_wr_out <= 1'b0;
                    idx_q      <= 3'h0;
                    if (mrb_q[`TFC_MRB_CHAIN])
                    begin
                        // Next descriptor, no flag or interrupt
                        base_q  <= base_q + `TFC_DESC_BYTES;
                        state_q <= S_FREQ;
                    end
                    else
                    begin
                        busy_out <= 1'b0;
                        state_q  <= S_IDLE;
                        if (mrb_q[`TFC_MRB_IRQSEL] || end_q)
                        begin
                            cpu_irq_out <= 1'b1;
                            last_irq_q  <= 1'b1;
                        end
                        else
                        begin
                            last_irq_q <= 1'b0;
                            if (from_sw_q)
                                sw_flag_q <= 1'b0;
                            else
                                src_flag_clr_out <= 1'b1;
                        end
                    end
                end
                default:
                begin
                    state_q <= S_IDLE;
                end
            endcase

            // Placed after the sequencer so a software set beats a hardware clear
            if (reg_wr_in)
            begin
                case (reg_addr_in)
                    `TFC_OFF_CTRL:  ctrl_en_q <= reg_wdata_in[0];
                    `TFC_OFF_DESC:  desc_q    <= reg_wdata_in[23:0];
                    `TFC_OFF_SWACT:
                    begin
                        sw_flag_q <= reg_wdata_in[0];
                        if (reg_wdata_in[0])
                            sw_pend_q <= 1'b1;
                    end
                    default: ;
                endcase
            end

            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    `TFC_OFF_CTRL:  reg_rdata_out <= {31'h00000000, ctrl_en_q};
                    `TFC_OFF_DESC:  reg_rdata_out <= {8'h00, desc_q};
                    `TFC_OFF_SWACT: reg_rdata_out <= {31'h00000000, sw_flag_q};
                    `TFC_OFF_STAT:  reg_rdata_out <= {28'h0000000, state_q != S_IDLE, sw_pend_q,
                                                      last_irq_q, sw_flag_q};
                    default:        reg_rdata_out <= 32'h00000000;
                endcase
            end
            else
                reg_rdata_out <= 32'h00000000;
        end
    end

endmodule
`default_nettype wire

/* File: tfc_properties.sv */
// Purpose: Port-level checks of the transfer controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Bound to tfc_core after the module
`default_nettype none
module tfc_properties (
    input wire logic        mclk_in,
    input wire logic        nrst_in,
    input wire logic        reg_rd_in,
    input wire logic [31:0] reg_rdata_out,
    input wire logic        act_req_in,
    input wire logic        act_ack_out,
    input wire logic        mem_rd_out,
    input wire logic        mem_wr_out,
    input wire logic        mem_word_out,
    input wire logic        cpu_irq_out,
    input wire logic        src_flag_clr_out,
    input wire logic        busy_out
);
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);

    // --------------------------------
    // Steps of an activation
    // --------------------------------
    sequence s_desc_fetch;
        ##[1:3] (mem_rd_out && mem_word_out);
    endsequence
    sequence s_pulse_gone;
        ##1 (!cpu_irq_out && !src_flag_clr_out);
    endsequence

    // --------------------------------
    // Assertions
    // --------------------------------
    chk_rdata_only_read: assert property (reg_rdata_out != 32'h0 |-> $past(reg_rd_in))
        else $error("read data outside read answer");
    chk_ack_cause: assert property (act_ack_out |-> $past(act_req_in) && !$past(busy_out) && busy_out)
        else $error("acknowledge without idle request");
    chk_ack_pulse: assert property (act_ack_out |=> !act_ack_out)
        else $error("acknowledge longer than one cycle");
    chk_fetch_start: assert property (act_ack_out |-> s_desc_fetch)
        else $error("descriptor fetch did not start");
    chk_irq_at_end: assert property (cpu_irq_out |-> $fell(busy_out) && !src_flag_clr_out)
        else $error("interrupt outside activation end");
    chk_clr_at_end: assert property (src_flag_clr_out |-> $fell(busy_out))
        else $error("flag clear outside activation end");
    chk_end_single: assert property ($fell(busy_out) |-> s_pulse_gone)
        else $error("end pulse longer than one cycle");
    chk_wb_burst: assert property ($fell(busy_out) |-> $past(mem_wr_out, 6) && $past(mem_wr_out))
        else $error("write-back burst missing before end");
    chk_idle_quiet: assert property (!busy_out |-> !mem_rd_out && !mem_wr_out)
        else $error("memory access while idle");
    chk_strobe_excl: assert property (!(mem_rd_out && mem_wr_out))
        else $error("read and write strobes together");
endmodule

bind tfc_core tfc_properties tfc_properties_inst (
    .mclk_in, .nrst_in, .reg_rd_in, .reg_rdata_out, .act_req_in, .act_ack_out, .mem_rd_out,
    .mem_wr_out, .mem_word_out, .cpu_irq_out, .src_flag_clr_out, .busy_out
);
`default_nettype wire

/* File: tfc_mem_model.sv */
// Purpose: Byte-addressed memory on the controller's far side
// Assumes: Every read answered in the next cycle, never waits
// Notes:   Halfwords big-endian; 4 KB mirrored over the space
`default_nettype none
module tfc_mem_model (
    input  wire logic        mclk_in,
    input  wire logic [23:0] mem_addr_in,
    input  wire logic [15:0] mem_wdata_in,
    input  wire logic        mem_wr_in,
    input  wire logic        mem_rd_in,
    input  wire logic        mem_word_in,
    output var  logic [15:0] mem_rdata_out
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0]  mem_q [0:4095];
    logic [11:0] a;
    assign a = mem_addr_in[11:0];
    initial mem_rdata_out = 16'h0;
    always @(posedge mclk_in)
    begin
        // Data toggles outside an answer so stale data never looks valid
        if (mem_rd_in)
            mem_rdata_out <= mem_word_in ? {mem_q[a], mem_q[a + 12'h1]} : {8'h00, mem_q[a]};
        else
            mem_rdata_out <= ~mem_rdata_out;
        if (mem_wr_in && mem_word_in)
        begin
            mem_q[a]         <= mem_wdata_in[15:8];
            mem_q[a + 12'h1] <= mem_wdata_in[7:0];
        end
        else if (mem_wr_in)
            mem_q[a] <= mem_wdata_in[7:0];
    end
endmodule
`default_nettype wire

/* File: tfc_core_bench.sv */
// Purpose: Self-checking bench of the transfer controller
// Assumes: Memory model answers reads in the next cycle
// Notes:   Descriptors are placed in the model directly
`default_nettype none
module tfc_core_bench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        mclk_in, nrst_in, reg_wr_in, reg_rd_in, act_req_in, act_ack_out;
    logic        mem_wr_out, mem_rd_out, mem_word_out, cpu_irq_out, src_flag_clr_out, busy_out;
    logic [7:0]  reg_addr_in;
    logic [31:0] reg_wdata_in, reg_rdata_out, rd;
    logic [23:0] act_addr_in, mem_addr_out;
    logic [15:0] mem_wdata_out, mem_rdata_in;
    int          fails = 0;
    int          num_checks = 0;

    tfc_core tfc_core_inst (
        .mclk_in, .nrst_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out,
        .act_req_in, .act_addr_in, .act_ack_out, .mem_addr_out, .mem_wdata_out, .mem_wr_out,
        .mem_rd_out, .mem_word_out, .mem_rdata_in, .cpu_irq_out, .src_flag_clr_out, .busy_out
    );
    tfc_mem_model tfc_mem_model_inst (
        .mclk_in, .mem_addr_in(mem_addr_out), .mem_wdata_in(mem_wdata_out), .mem_wr_in(mem_wr_out),
        .mem_rd_in(mem_rd_out), .mem_word_in(mem_word_out), .mem_rdata_out(mem_rdata_in)
    );

    // --------------------------------
    // Shared tasks
    // --------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    function automatic logic [7:0] get8(input logic [23:0] a);
        return tfc_mem_model_inst.mem_q[a[11:0]];
    endfunction
    function automatic logic [15:0] get16(input logic [23:0] a);
        return {get8(a), get8(a + 24'h1)};
    endfunction
    function automatic logic [23:0] ptr_of(input logic [23:0] a);
        return {get8(a + 24'h1), get16(a + 24'h2)};
    endfunction
    task automatic put_desc(input logic [23:0] b, input logic [7:0] ma, input logic [23:0] s,
                            input logic [7:0] mb, input logic [23:0] d, input logic [15:0] ca);
        logic [15:0] w [6];
        w = '{{ma, s[23:16]}, s[15:0], {mb, d[23:16]}, d[15:0], ca, 16'h0002};
        for (int i = 0; i < 6; i++)
        begin
            tfc_mem_model_inst.mem_q[b[11:0] + 12'(2 * i)]     = w[i][15:8];
            tfc_mem_model_inst.mem_q[b[11:0] + 12'(2 * i + 1)] = w[i][7:0];
        end
    endtask
    task automatic reg_access(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        reg_addr_in  <= a;
        reg_wdata_in <= d;
        reg_wr_in    <= wr;
        reg_rd_in    <= !wr;
        @(posedge mclk_in);
        reg_wr_in    <= 1'b0;
        reg_rd_in    <= 1'b0;
        @(posedge mclk_in);
        rd = reg_rdata_out;
    endtask
    task automatic activate(input logic [23:0] b, input int e_irq, input int e_clr);
        int k;
        int n_irq;
        int n_clr;
        k = 0;
        n_irq = 0;
        n_clr = 0;
        @(posedge mclk_in);
        act_addr_in <= b;
        act_req_in  <= 1'b1;
        while (act_ack_out !== 1'b1 && k < 20)
        begin
            @(posedge mclk_in);
            k++;
        end
        act_req_in <= 1'b0;
        check("ack", 1, k < 20);
        while (busy_out === 1'b1 && k < 4000)
        begin
            @(posedge mclk_in);
            n_irq += (cpu_irq_out === 1'b1);
            n_clr += (src_flag_clr_out === 1'b1);
            k++;
        end
        check("done", 1, k < 4000);
        check("irq", e_irq, n_irq);
        check("clr", e_clr, n_clr);
    endtask

    // --------------------------------
    // Scenarios
    // --------------------------------
    task automatic t_regs();
        reg_access(1'b0, 8'h00, 32'h0);
        check("ctrl reset", 32'h0, rd);
        reg_access(1'b1, 8'h00, 32'h1);
        reg_access(1'b0, 8'h00, 32'h0);
        check("ctrl", 32'h1, rd);
        reg_access(1'b0, 8'h3c, 32'h0);
        check("unmapped", 32'h0, rd);
        reg_access(1'b0, 8'h0c, 32'h0);
        check("status", 32'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_normal();
        put_desc(24'h100, 8'ha0, 24'h200, 8'h00, 24'h300, 16'h0002);
        activate(24'h100, 0, 1);
        check("unit", 8'h20, get8(24'h300));
        check("one unit", 8'h31, get8(24'h301));
        check("src", 24'h201, ptr_of(24'h100));
        check("dst", 24'h301, ptr_of(24'h104));
        check("count", 16'h1, get16(24'h108));
        activate(24'h100, 1, 0);
        check("unit2", 8'h21, get8(24'h301));
        $display("test normal done");
    endtask
    task automatic t_repeat();
        put_desc(24'h120, 8'ha6, 24'h210, 8'h00, 24'h320, 16'h0202);
        activate(24'h120, 0, 1);
        check("count", 16'h0201, get16(24'h128));
        activate(24'h120, 0, 1);
        check("src restored", 24'h210, ptr_of(24'h120));
        check("count reload", 16'h0202, get16(24'h128));
        activate(24'h120, 0, 1);
        check("repeat unit", 8'h20, get8(24'h322));
        put_desc(24'h140, 8'ha6, 24'h210, 8'h00, 24'h330, 16'h0000);
        activate(24'h140, 0, 1);
        check("zero count", 16'h00ff, get16(24'h148));
        $display("test repeat done");
    endtask
    task automatic t_block();
        put_desc(24'h160, 8'haa, 24'h230, 8'h00, 24'h340, 16'h0303);
        activate(24'h160, 0, 1);
        for (int i = 0; i < 3; i++)
            check("block unit", 8'h20 + i, get8(24'h340 + 24'(i)));
        check("area back", 24'h230, ptr_of(24'h160));
        check("size back", 16'h0303, get16(24'h168));
        check("other step", 24'h343, ptr_of(24'h164));
        activate(24'h160, 1, 0);
        put_desc(24'h1a0, 8'he8, 24'h25f, 8'h00, 24'h360, 16'h0202);
        activate(24'h1a0, 0, 1);
        check("dec unit", 8'h2e, get8(24'h361));
        check("src down", 24'h25d, ptr_of(24'h1a0));
        check("dst area", 24'h360, ptr_of(24'h1a4));
        $display("test block done");
    endtask
    task automatic t_chain();
        put_desc(24'h1c0, 8'ha0, 24'h240, 8'h80, 24'h370, 16'h0001);
        put_desc(24'h1cc, 8'ha1, 24'h250, 8'h00, 24'h380, 16'h0005);
        activate(24'h1c0, 0, 1);
        check("first", 8'h20, get8(24'h370));
        check("second", 16'h2021, get16(24'h380));
        check("count b", 16'h4, get16(24'h1d4));
        $display("test chain done");
    endtask
    task automatic t_soft();
        reg_access(1'b1, 8'h04, 32'h1a0);
        reg_access(1'b1, 8'h08, 32'h1);
        reg_access(1'b0, 8'h0c, 32'h0);
        check("stat busy", 32'h9, rd);
        wait (busy_out === 1'b0);
        reg_access(1'b0, 8'h0c, 32'h0);
        check("stat end", 32'h3, rd);
        $display("test soft done");
    endtask

    initial
    begin
        mclk_in = 1'b0;
        forever #5 mclk_in = ~mclk_in;
    end
    initial
    begin
        #200000;
        fails++;
        $display("mismatch watchdog expected finish seen hang");
        report_and_stop();
    end
    initial
    begin
        {nrst_in, reg_wr_in, reg_rd_in, act_req_in, reg_addr_in, reg_wdata_in, act_addr_in} = '0;
        for (int i = 0; i < 4096; i++)
            tfc_mem_model_inst.mem_q[i] = {i[11:8], i[3:0]};
        repeat (2) @(posedge mclk_in);
        nrst_in <= 1'b1;
        t_regs();
        t_normal();
        t_repeat();
        t_block();
        t_chain();
        t_soft();
        report_and_stop();
    end
endmodule
`default_nettype wire
